// >>> hw/lcd_frame_clock_map.svh
// Register map, field positions, reset values and timing constants of the LCD frame clock generator
// Notes on behaviour
// - Prescaler tap divides by 16 up to 4096
// - Tap output further divided by code plus one
// - Cascade output is the prescaled panel clock
// - Frame is 8*N*(div+1) for most duties
// - One-third duty frame is 6*N*(div+1)
// - Frame rate bits 7 and 3 read zero
// - Contrast code sets peak voltage linearly
// - New contrast code applied at frame start
// - Contrast register upper nibble reads zero
// - Source select picks system or asynchronous clock
// - Common count field selects the duty
`ifndef LCD_FRAME_CLOCK_MAP_SVH
`define LCD_FRAME_CLOCK_MAP_SVH
`define FRR_OFFSET      12'h000
`define CCR_OFFSET      12'h004
`define CTRL_OFFSET     12'h008
`define STAT_OFFSET     12'h00c
`define FRR_RESET       8'h00
`define CCR_RESET       8'h00
`define CTRL_RESET      8'h00
`define FRR_WMASK       8'h77
`define CCR_WMASK       8'h0f
`define CTRL_WMASK      8'hb1
`define FRR_TAP_LSB     4
`define FRR_DIV_LSB     0
`define CTRL_EN_BIT     0
`define CTRL_MUX_LSB    4
`define CTRL_CS_BIT     7
`define FRAME_K_NORMAL  4'd8
`define FRAME_K_THIRD   4'd6
`endif

// >>> hw/lcd_frame_clock_pkg.sv
// Types shared by the LCD frame clock generator
package lcd_frame_clock_pkg;
    typedef enum logic [1:0] {
        duty_static  = 2'b00,
        duty_half    = 2'b01,
        duty_third   = 2'b10,
        duty_quarter = 2'b11
    } duty_e;
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_run   = 3'b010,
        st_apply = 3'b100
    } seq_state_e;
endpackage

// >>> hw/lcd_clock_divider.sv
// Cascaded prescaler tap and divider producing the prescaled panel clock enable
module lcd_clock_divider
    import lcd_frame_clock_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       src_tick,
    input  wire logic [2:0] tap_sel,
    input  wire logic [2:0] div_sel,
    output logic            ps_tick
);
    // Tap period minus one for each select code
    function automatic logic [11:0] tap_last(input logic [2:0] sel);
        case (sel)
            3'h0:    tap_last = 12'h00f;
            3'h1:    tap_last = 12'h03f;
            3'h2:    tap_last = 12'h07f;
            3'h3:    tap_last = 12'h0ff;
            3'h4:    tap_last = 12'h1ff;
            3'h5:    tap_last = 12'h3ff;
            3'h6:    tap_last = 12'h7ff;
            default: tap_last = 12'hfff;
        endcase
    endfunction

    logic [11:0] pre_q;
    logic [2:0]  div_q;
    wire         tap_wrap = src_tick && (pre_q >= tap_last(tap_sel));
    wire         div_wrap = tap_wrap && (div_q >= div_sel);

    // Both counters clear while stopped so an enable starts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q   <= 12'h000;
            div_q   <= 3'h0;
            ps_tick <= 1'b0;
        end else if (!run) begin
            pre_q   <= 12'h000;
            div_q   <= 3'h0;
            ps_tick <= 1'b0;
        end else begin
            if (src_tick) begin
                pre_q <= tap_wrap ? 12'h000 : pre_q + 12'h001;
            end
            if (tap_wrap) begin
                div_q <= div_wrap ? 3'h0 : div_q + 3'h1;
            end
            ps_tick <= div_wrap;
        end
    end
endmodule

// >>> hw/lcd_frame_clock_gen.sv
// APB register slave and frame sequencer of the LCD frame clock generator
//
// Added by the designer: register access over APB and the placing of the registers.
`include "lcd_frame_clock_map.svh"
module lcd_frame_clock_gen
    import lcd_frame_clock_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        async_clk,
    output logic             prescaled_panel_clock,
    output logic             frame_start,
    output logic [3:0]       contrast_code,
    output logic [1:0]       active_duty
);
    logic [7:0] frame_rate_control_q;
    logic [7:0] contrast_control_q;
    logic [7:0] ctrl_q;
    logic [2:0] async_sync_q;
    logic [3:0] phase_q;
    logic       ps_tick;
    seq_state_e state_q;
    seq_state_e state_d;

    // APB decode; the slave answers in the first access cycle
    wire access   = psel && penable;
    wire wr_en    = access && pwrite;
    wire hit_frr  = (paddr == `FRR_OFFSET);
    wire hit_ccr  = (paddr == `CCR_OFFSET);
    wire hit_ctrl = (paddr == `CTRL_OFFSET);
    wire hit_stat = (paddr == `STAT_OFFSET);
    wire mapped   = hit_frr || hit_ccr || hit_ctrl || hit_stat;

    // Control fields
    wire        enable     = ctrl_q[`CTRL_EN_BIT];
    wire        src_select = ctrl_q[`CTRL_CS_BIT];
    duty_e      duty;
    assign duty = duty_e'(ctrl_q[`CTRL_MUX_LSB +: 2]);
    wire [2:0]  tap_sel    = frame_rate_control_q[`FRR_TAP_LSB +: 3];
    wire [2:0]  div_sel    = frame_rate_control_q[`FRR_DIV_LSB +: 3];

    // Asynchronous clock is sampled through two flops; its rising edge is one source tick
    wire async_edge = async_sync_q[1] && !async_sync_q[2];
    wire src_tick   = src_select ? async_edge : 1'b1;

    // Prescaled ticks per frame depend on duty
    wire [3:0] frame_k  = (duty == duty_third) ? `FRAME_K_THIRD : `FRAME_K_NORMAL;
    wire [3:0] k_last   = frame_k - 4'd1;
    wire       frame_end = ps_tick && (phase_q >= k_last);

    // Read mux; reserved bits read zero because the stored value never holds them
    wire [7:0] stat_word = {1'b0, state_q == st_run, active_duty, contrast_code};
    wire [7:0] rd_byte   = hit_frr  ? frame_rate_control_q :
                           hit_ccr  ? contrast_control_q :
                           hit_ctrl ? ctrl_q :
                           hit_stat ? stat_word : 8'h00;

    lcd_clock_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (enable),
        .src_tick(src_tick),
        .tap_sel (tap_sel),
        .div_sel (div_sel),
        .ps_tick (ps_tick)
    );

    // Frame sequencer: idle while disabled, apply latches settings at frame start
    always_comb begin
        case (state_q)
            st_idle:  state_d = enable ? st_apply : st_idle;
            st_run:   state_d = !enable ? st_idle : (frame_end ? st_apply : st_run);
            st_apply: state_d = enable ? st_run : st_idle;
            default:  state_d = st_idle;
        endcase
    end

    // Register writes; masks drop reserved bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_rate_control_q <= `FRR_RESET;
            contrast_control_q   <= `CCR_RESET;
            ctrl_q               <= `CTRL_RESET;
        end else if (wr_en) begin
            if (hit_frr)  frame_rate_control_q <= pwdata[7:0] & `FRR_WMASK;
            if (hit_ccr)  contrast_control_q   <= pwdata[7:0] & `CCR_WMASK;
            if (hit_ctrl) ctrl_q               <= pwdata[7:0] & `CTRL_WMASK;
        end
    end

    // APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // Synchroniser and frame phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_sync_q <= 3'b000;
            phase_q      <= 4'h0;
            state_q      <= st_idle;
        end else begin
            async_sync_q <= {async_sync_q[1:0], async_clk};
            state_q      <= state_d;
            if (!enable || state_q != st_run) phase_q <= 4'h0;
            else if (ps_tick) phase_q <= frame_end ? 4'h0 : phase_q + 4'h1;
        end
    end

    // Contrast code and duty latched at each frame start, pulse outputs registered every cycle; contrast code holds until then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contrast_code         <= 4'h0;
            active_duty           <= 2'b00;
            frame_start           <= 1'b0;
            prescaled_panel_clock <= 1'b0;
        end else begin
            frame_start           <= (state_q == st_apply);
            prescaled_panel_clock <= ps_tick;
            if (state_q == st_apply) begin
                contrast_code <= contrast_control_q[3:0];
                active_duty   <= duty;
            end
        end
    end

    a_contrast_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(contrast_code) |-> $past(state_q) == st_apply)
        else $error("contrast code changed outside frame start");
    a_frr_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (frame_rate_control_q & 8'h88) == 8'h00)
        else $error("frame rate reserved bit set");
    a_ccr_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        contrast_control_q[7:4] == 4'h0)
        else $error("contrast reserved bits set");
    a_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !enable && $past(!enable) |=> !prescaled_panel_clock && phase_q == 4'h0)
        else $error("sequencer active while disabled");
    a_third_frame: assert property (@(posedge pclk) disable iff (!presetn)
        frame_end && duty == duty_third |-> phase_q == 4'd5)
        else $error("one-third duty frame length wrong");
    a_normal_frame: assert property (@(posedge pclk) disable iff (!presetn)
        frame_end && duty != duty_third |-> phase_q == 4'd7)
        else $error("frame length wrong");
    a_sync_src: assert property (@(posedge pclk) disable iff (!presetn)
        !src_select |-> src_tick)
        else $error("system clock source not ticking");
    a_tap_min: assert property (@(posedge pclk) disable iff (!presetn)
        ps_tick && !src_select |=> !ps_tick [*8])
        else $error("prescaled tick too soon");
    a_frame_start: assert property (@(posedge pclk) disable iff (!presetn)
        frame_end && enable |=> ##1 frame_start)
        else $error("frame start missing after frame end");
    c_frame: cover property (@(posedge pclk) frame_start);
    c_third: cover property (@(posedge pclk) frame_end && duty == duty_third);
    c_async: cover property (@(posedge pclk) ps_tick && src_select);
    c_contrast: cover property (@(posedge pclk) $changed(contrast_code));
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the LCD frame clock generator
`include "lcd_frame_clock_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, async_clk, pready, pslverr, err_q;
    logic        prescaled_panel_clock, frame_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0]  contrast_code;
    logic [1:0]  active_duty, acnt;
    int          num_errors, cmp_count, g, m;
    int          nt[8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
    logic [2:0]  tp[4] = '{3'h0, 3'h1, 3'h0, 3'h0};
    logic [2:0]  dv[4] = '{3'h0, 3'h1, 3'h2, 3'h0};
    logic [1:0]  dt[4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    logic        cs[4] = '{1'b0, 1'b0, 1'b0, 1'b1};

    lcd_frame_clock_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .async_clk(async_clk), .prescaled_panel_clock(prescaled_panel_clock),
        .frame_start(frame_start), .contrast_code(contrast_code), .active_duty(active_duty));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Slow asynchronous source, one rising edge every 4 pclk so the synchroniser never drops one
    always @(posedge pclk) begin
        acnt      <= acnt + 2'h1;
        async_clk <= acnt[1];
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        chk(32'h0, 32'h1, msg);
        summarize();
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look between edges so the registered answer has settled
        for (n = 0; n < 20; n++) begin
            @(negedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) fail("no pready");
        rd_q    = prdata;
        err_q   = pslverr;
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp, msg);
    endtask

    // Cycles between the second and third pulse of a frame or tick output
    task automatic gap(input logic fs);
        int n, seen;
        seen = 0;
        g    = 0;
        for (n = 0; n < 40000 && seen < 3; n++) begin
            @(negedge pclk);
            g++;
            if ((fs ? frame_start : prescaled_panel_clock) === 1'b1) begin
                seen++;
                if (seen == 2) g = 0;
            end
        end
        if (seen < 3) fail("no pulse");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        acnt = 2'h0;
        async_clk = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and reserved bits
        rd(`FRR_OFFSET, 32'h0, "frr reset");
        rd(`CCR_OFFSET, 32'h0, "ccr reset");
        apb(1'b1, `FRR_OFFSET, 32'hff);
        rd(`FRR_OFFSET, 32'h77, "frr mask");
        apb(1'b1, `CCR_OFFSET, 32'hff);
        rd(`CCR_OFFSET, 32'h0f, "ccr mask");
        apb(1'b1, 12'h010, 32'h5a);
        chk(err_q, 1'b1, "unmapped err");
        rd(12'h010, 32'h0, "unmapped read");
        // Tap, divider, duty and source table; reserved bit 3 written high on purpose
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `CTRL_OFFSET, 32'h0);
            apb(1'b1, `FRR_OFFSET, 32'({tp[i], 1'b1, dv[i]}));
            apb(1'b1, `CTRL_OFFSET, 32'({cs[i], 1'b0, dt[i], 4'h1}));
            m = nt[tp[i]] * (int'(dv[i]) + 1) * (cs[i] ? 4 : 1);
            gap(1'b0);
            chk(g, m, "tick spacing");
            gap(1'b1);
            chk(g, (dt[i] == 2'h2 ? 6 : 8) * m, "frame length");
            chk(active_duty, dt[i], "duty");
        end
        // Disabled counters stay quiet
        apb(1'b1, `CTRL_OFFSET, 32'h0);
        m = 0;
        repeat (100) begin
            @(negedge pclk);
            if (prescaled_panel_clock === 1'b1) m++;
        end
        chk(m, 0, "held while off");
        // New contrast code waits for the next frame boundary
        apb(1'b1, `CTRL_OFFSET, 32'h31);
        gap(1'b1);
        apb(1'b1, `CCR_OFFSET, 32'h5);
        chk(contrast_code, 32'hf, "old code kept");
        for (m = 0; m < 200 && frame_start !== 1'b1; m++) @(negedge pclk);
        if (m == 200) fail("no frame");
        repeat (2) @(posedge pclk);
        chk(contrast_code, 32'h5, "new code");
        rd(`STAT_OFFSET, 32'h75, "status");
        summarize();
    end
endmodule
